// ==== rtl/irq_monitor_map.svh ====
// register offsets, field positions, reset values and timing constants
`ifndef IRQ_MONITOR_MAP_SVH
`define IRQ_MONITOR_MAP_SVH

`define ADDR_GENERAL_INPUT_LEVELS  8'h2F
`define ADDR_INTERRUPT_SETUP       8'h32
`define ADDR_INTERRUPT_SOURCE_MASK 8'h33
`define ADDR_LATCHED_EVENT_FLAGS   8'h36

`define SETUP_POL_BIT    7
`define SETUP_MODE_HI    6
`define SETUP_MODE_LO    5
`define SETUP_FILT_BIT   2
`define SETUP_RESET      8'h00

`define SRC_CLKERR_BIT   7
`define SRC_PLL_BIT      6
`define SRC_LO_BIT       6
`define MASK_RESET       8'hFF
`define LATCH_RESET      8'h00

`define MON_HI_BIT       7
`define MON_LO_BIT       4

`define FUNC_GPI         3'h1

`define MODE_LEVEL       2'h0
`define MODE_RESERVED    2'h1
`define MODE_REPEAT      2'h2
`define MODE_ONESHOT     2'h3

`define CLK_PERIOD_NS    10
`define IRQ_PULSE_NS     2000000
`define IRQ_PERIOD_NS    4000000

`endif

// ==== rtl/irq_monitor_pkg.sv ====
// types shared by the interrupt and input monitor block
package irq_monitor_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } reg_rsp_t;

  typedef struct packed {
    logic       pol;
    logic [1:0] mode;
    logic       filt;
  } irq_setup_t;

  typedef enum logic [1:0] {PS_IDLE, PS_ON, PS_OFF} pulse_state_t;

endpackage

// ==== rtl/level_sync.sv ====
// two-flop synchroniser for asynchronous input pins
module level_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff  <= '0;
      sync_out <= '0;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

// ==== rtl/event_latch.sv ====
// one sticky event flag, set wins over clear
module event_latch (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // control
  input  wire logic set,
  input  wire logic clr,
  output logic      flag_ff
);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else if (set) begin
      flag_ff <= 1'b1;
    end else if (clr) begin
      flag_ff <= 1'b0;
    end
  end

endmodule

// ==== rtl/audio_adc_irq_and_gpi_monitor.sv ====
// interrupt latches, masks, pin timing and general input monitor
`include "irq_monitor_map.svh"

module audio_adc_irq_and_gpi_monitor #(
  parameter int PULSE_CYCLES  = `IRQ_PULSE_NS / `CLK_PERIOD_NS,
  parameter int PERIOD_CYCLES = `IRQ_PERIOD_NS / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // control port
  input  wire irq_monitor_pkg::reg_req_t reg_req,
  output irq_monitor_pkg::reg_rsp_t      reg_rsp,
  // event pulses from device logic
  input  wire logic                      audio_port_clk_err,
  input  wire logic                      pll_lock_evt,
  // general input pins and their function selects
  input  wire logic [3:0]                gpi_pin,
  input  wire logic [2:0]                input1_function_select,
  input  wire logic [2:0]                input2_function_select,
  input  wire logic [2:0]                input3_function_select,
  input  wire logic [2:0]                input4_function_select,
  // interrupt pin
  output logic                           irq_out
);
  import irq_monitor_pkg::*;

  localparam int CNT_W = $clog2(PERIOD_CYCLES + 1);
  localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYCLES - 1);
  localparam logic [CNT_W-1:0] GAP_LAST   = CNT_W'(PERIOD_CYCLES - PULSE_CYCLES - 1);

  // reset release
  logic [1:0] rst_pipe_ff;
  logic       rst_q_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_ff <= 2'h0;
    end else begin
      rst_pipe_ff <= {rst_pipe_ff[0], 1'b1};
    end
  end
  assign rst_q_n = rst_pipe_ff[1];

  // input pins
  logic [3:0] gpi_sync;
  logic [3:0] gpi_is_input;
  logic [3:0] input_level;

  level_sync #(.W(4)) u_gpi_sync (
    .clk      (clk),
    .rst_n    (rst_q_n),
    .async_in (gpi_pin),
    .sync_out (gpi_sync)
  );

  assign gpi_is_input = {input1_function_select == `FUNC_GPI,
                         input2_function_select == `FUNC_GPI,
                         input3_function_select == `FUNC_GPI,
                         input4_function_select == `FUNC_GPI};
  // pin 1 lands in bit 7, pin 4 in bit 4
  assign input_level = {gpi_sync[0], gpi_sync[1], gpi_sync[2], gpi_sync[3]}
                       & gpi_is_input;

  // configuration registers
  irq_setup_t setup_ff;
  logic [7:0] mask_ff;
  logic       wr_setup;
  logic       wr_mask;

  assign wr_setup = reg_req.wr && (reg_req.addr == `ADDR_INTERRUPT_SETUP);
  assign wr_mask  = reg_req.wr && (reg_req.addr == `ADDR_INTERRUPT_SOURCE_MASK);

  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      setup_ff <= '0;
    end else if (wr_setup) begin
      setup_ff.pol  <= reg_req.wdata[`SETUP_POL_BIT];
      setup_ff.mode <= reg_req.wdata[`SETUP_MODE_HI:`SETUP_MODE_LO];
      setup_ff.filt <= reg_req.wdata[`SETUP_FILT_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      mask_ff <= `MASK_RESET;
    end else if (wr_mask) begin
      mask_ff <= reg_req.wdata; // reserved low bits stay writable
    end
  end

  // event latches, index 1 = clock error (bit 7), 0 = lock (bit 6)
  logic [1:0] evt_in;
  logic [1:0] src_mask;
  logic [1:0] latch_q;
  logic [1:0] latch_seen;
  logic [1:0] latch_clr;
  logic       rd_latch;

  assign evt_in   = {audio_port_clk_err, pll_lock_evt};
  assign src_mask = mask_ff[`SRC_CLKERR_BIT:`SRC_PLL_BIT];
  assign rd_latch = reg_req.rd && (reg_req.addr == `ADDR_LATCHED_EVENT_FLAGS);
  // filter hides masked flags, and a hidden flag is not cleared by the read
  assign latch_seen = setup_ff.filt ? (latch_q & ~src_mask) : latch_q;
  assign latch_clr  = rd_latch ? latch_seen : 2'h0;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_src
      event_latch u_latch (
        .clk     (clk),
        .rst_n   (rst_q_n),
        .set     (evt_in[gi]),
        .clr     (latch_clr[gi]),
        .flag_ff (latch_q[gi])
      );
    end
  endgenerate

  // register reads, answer one cycle after the strobe
  logic [7:0] nxt_rd_data;
  reg_rsp_t   rsp_ff;

  always_comb begin
    nxt_rd_data = 8'h00;
    case (reg_req.addr)
      `ADDR_GENERAL_INPUT_LEVELS: begin
        nxt_rd_data[`MON_HI_BIT:`MON_LO_BIT] = input_level;
      end
      `ADDR_INTERRUPT_SETUP: begin
        nxt_rd_data[`SETUP_POL_BIT]                 = setup_ff.pol;
        nxt_rd_data[`SETUP_MODE_HI:`SETUP_MODE_LO]  = setup_ff.mode;
        nxt_rd_data[`SETUP_FILT_BIT]                = setup_ff.filt;
      end
      `ADDR_INTERRUPT_SOURCE_MASK: begin
        nxt_rd_data = mask_ff;
      end
      `ADDR_LATCHED_EVENT_FLAGS: begin
        nxt_rd_data[`SRC_CLKERR_BIT:`SRC_PLL_BIT] = latch_seen;
      end
      default: begin
        nxt_rd_data = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= reg_req.rd;
      if (reg_req.rd) begin
        rsp_ff.data <= nxt_rd_data;
      end
    end
  end
  assign reg_rsp = rsp_ff;

  // interrupt timing
  logic         pending;
  logic         new_evt;
  pulse_state_t state_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic         active_ff;
  logic         nxt_active;

  assign pending = |(latch_q & ~src_mask);
  assign new_evt = |(evt_in & ~src_mask);

  // one-shot pulses ignore events arriving while a pulse is running
  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      state_ff <= PS_IDLE;
      cnt_ff   <= '0;
    end else begin
      case (setup_ff.mode)
        `MODE_REPEAT: begin
          case (state_ff)
            PS_IDLE: begin
              if (pending) begin
                state_ff <= PS_ON;
                cnt_ff   <= '0;
              end
            end
            PS_ON: begin
              if (!pending) begin
                state_ff <= PS_IDLE;
              end else if (cnt_ff == PULSE_LAST) begin
                state_ff <= PS_OFF;
                cnt_ff   <= '0;
              end else begin
                cnt_ff <= cnt_ff + 1'b1;
              end
            end
            PS_OFF: begin
              if (!pending) begin
                state_ff <= PS_IDLE;
              end else if (cnt_ff == GAP_LAST) begin
                state_ff <= PS_ON;
                cnt_ff   <= '0;
              end else begin
                cnt_ff <= cnt_ff + 1'b1;
              end
            end
            default: begin
              state_ff <= PS_IDLE;
            end
          endcase
        end
        `MODE_ONESHOT: begin
          case (state_ff)
            PS_ON: begin
              if (cnt_ff == PULSE_LAST) begin
                state_ff <= PS_IDLE;
              end else begin
                cnt_ff <= cnt_ff + 1'b1;
              end
            end
            default: begin
              if (new_evt) begin
                state_ff <= PS_ON;
                cnt_ff   <= '0;
              end else begin
                state_ff <= PS_IDLE;
              end
            end
          endcase
        end
        default: begin
          state_ff <= PS_IDLE;
          cnt_ff   <= '0;
        end
      endcase
    end
  end

  always_comb begin
    case (setup_ff.mode)
      `MODE_LEVEL:   nxt_active = pending;
      `MODE_REPEAT:  nxt_active = pending && (state_ff == PS_ON);
      `MODE_ONESHOT: nxt_active = (state_ff == PS_ON);
      default:       nxt_active = 1'b0; // reserved code keeps the pin idle
    endcase
  end

  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      active_ff <= 1'b0;
      irq_out   <= 1'b1;
    end else begin
      active_ff <= nxt_active;
      irq_out   <= setup_ff.pol ? nxt_active : ~nxt_active;
    end
  end

  // checks
  logic [CNT_W:0] on_len_ff;
  logic [1:0]     mode_q;

  always_ff @(posedge clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      on_len_ff <= '0;
      mode_q    <= `MODE_LEVEL;
    end else begin
      mode_q    <= setup_ff.mode;
      on_len_ff <= active_ff ? on_len_ff + 1'b1 : '0;
    end
  end

  sequence s_gap_done;
    setup_ff.mode == `MODE_REPEAT && state_ff == PS_OFF && cnt_ff == GAP_LAST && pending;
  endsequence
  sequence s_pulse_restart;
    state_ff == PS_ON ##1 active_ff;
  endsequence
  sequence s_latch_read;
    rd_latch && !(|evt_in) && (|latch_seen);
  endsequence

  chk_monitor_bits: assert property (@(posedge clk) disable iff (!rst_q_n)
    reg_req.rd && reg_req.addr == `ADDR_GENERAL_INPUT_LEVELS
    |=> reg_rsp.valid && reg_rsp.data[3:0] == 4'h0
        && reg_rsp.data[`MON_HI_BIT] == $past(gpi_sync[0] && gpi_is_input[3]))
    else $error("monitor readback wrong");

  chk_pin_polarity: assert property (@(posedge clk) disable iff (!rst_q_n)
    irq_out == ($past(setup_ff.pol) ? active_ff : !active_ff))
    else $error("interrupt pin polarity wrong");

  chk_level_follow: assert property (@(posedge clk) disable iff (!rst_q_n)
    setup_ff.mode == `MODE_LEVEL && pending |=> active_ff)
    else $error("level mode did not assert");

  chk_reserved_idle: assert property (@(posedge clk) disable iff (!rst_q_n)
    setup_ff.mode == `MODE_RESERVED |=> !active_ff)
    else $error("reserved mode drove the pin");

  chk_repeat_restart: assert property (@(posedge clk) disable iff (!rst_q_n)
    s_gap_done |=> s_pulse_restart)
    else $error("repeat pulse did not restart");

  chk_oneshot_width: assert property (@(posedge clk) disable iff (!rst_q_n)
    $fell(active_ff) && mode_q == `MODE_ONESHOT && $past(mode_q) == `MODE_ONESHOT
    |-> $past(on_len_ff) == (CNT_W + 1)'(PULSE_CYCLES - 1))
    else $error("one-shot pulse width wrong");

  chk_readback_filter: assert property (@(posedge clk) disable iff (!rst_q_n)
    rd_latch && setup_ff.filt
    |=> (reg_rsp.data[`SRC_CLKERR_BIT:`SRC_PLL_BIT] & $past(src_mask)) == 2'h0)
    else $error("masked latch visible");

  chk_mask_reset: assert property (@(posedge clk)
    $rose(rst_q_n) |-> mask_ff == `MASK_RESET)
    else $error("mask reset value wrong");

  chk_latch_catch: assert property (@(posedge clk) disable iff (!rst_q_n)
    audio_port_clk_err |=> latch_q[1] ##1 (latch_q[1] || $past(rd_latch)))
    else $error("clock error not latched");

  chk_read_clears: assert property (@(posedge clk) disable iff (!rst_q_n)
    s_latch_read |=> (latch_q & $past(latch_seen)) == 2'h0)
    else $error("latch not cleared by read");

  chk_level_release: assert property (@(posedge clk) disable iff (!rst_q_n)
    setup_ff.mode == `MODE_LEVEL && !pending |=> !active_ff)
    else $error("level mode did not release");

endmodule

// ==== bench/host_model.sv ====
// host side model: control port reads and writes
module host_model (
  // clock
  input  wire logic                      clk,
  // control port
  output irq_monitor_pkg::reg_req_t      reg_req,
  input  wire irq_monitor_pkg::reg_rsp_t reg_rsp
);
  timeunit 1ns;
  timeprecision 100ps;
  import irq_monitor_pkg::*;

  initial reg_req = '0;

  // released lines flip so a stale address never looks live
  task automatic idle();
    reg_req.addr  <= ~reg_req.addr;
    reg_req.wdata <= ~reg_req.wdata;
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req.wr    <= 1'b1;
    reg_req.addr  <= a;
    reg_req.wdata <= d;
    @(posedge clk);
    reg_req.wr <= 1'b0;
    idle();
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d  = 8'h00;
    @(posedge clk);
    reg_req.rd   <= 1'b1;
    reg_req.addr <= a;
    @(posedge clk);
    reg_req.rd <= 1'b0;
    idle();
    // valid stands one cycle only, so it is taken at the edge that samples it
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk);
      if (reg_rsp.valid === 1'b1) begin
        d  = reg_rsp.data;
        ok = 1'b1;
      end
    end
  endtask
endmodule

// ==== bench/audio_adc_irq_and_gpi_monitor_bench.sv ====
// self-checking bench for the interrupt and input monitor block
`include "irq_monitor_map.svh"

module audio_adc_irq_and_gpi_monitor_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import irq_monitor_pkg::*;

  localparam int PULSE  = 20;
  localparam int PERIOD = 40;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] exp;
  } row_t;

  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       audio_port_clk_err = 1'b0;
  logic       pll_lock_evt = 1'b0;
  logic [3:0] gpi_pin = 4'hF;
  logic [2:0] sel [4] = '{3'h0, 3'h0, 3'h0, 3'h0};
  logic       irq_out;
  reg_req_t   reg_req;
  reg_rsp_t   reg_rsp;
  int         error_cnt = 0;
  int         check_count = 0;
  logic [7:0] d;
  int         n;
  row_t       rows [11] = '{
    '{1'b0, 8'h33, 8'h00, 8'hFF}, '{1'b0, 8'h32, 8'h00, 8'h00},
    '{1'b0, 8'h36, 8'h00, 8'h00}, '{1'b0, 8'h2F, 8'h00, 8'h00},
    '{1'b1, 8'h32, 8'hFF, 8'hE4}, '{1'b1, 8'h32, 8'h00, 8'h00},
    '{1'b1, 8'h33, 8'h3F, 8'h3F}, '{1'b1, 8'h36, 8'hFF, 8'h00},
    '{1'b1, 8'h2F, 8'hFF, 8'h00}, '{1'b1, 8'h10, 8'h5A, 8'h00},
    '{1'b1, 8'h33, 8'hFF, 8'hFF}};

  always #5 clk = ~clk;

  host_model host (
    .clk     (clk),
    .reg_req (reg_req),
    .reg_rsp (reg_rsp)
  );

  audio_adc_irq_and_gpi_monitor #(
    .PULSE_CYCLES  (PULSE),
    .PERIOD_CYCLES (PERIOD)
  ) dut (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .reg_req                (reg_req),
    .reg_rsp                (reg_rsp),
    .audio_port_clk_err     (audio_port_clk_err),
    .pll_lock_evt           (pll_lock_evt),
    .gpi_pin                (gpi_pin),
    .input1_function_select (sel[0]),
    .input2_function_select (sel[1]),
    .input3_function_select (sel[2]),
    .input4_function_select (sel[3]),
    .irq_out                (irq_out)
  );

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic get(input logic [7:0] a);
    bit ok;
    host.read_reg(a, d, ok);
    if (!ok) begin
      error_cnt++;
      $display("[ERR] %0t read answer missing", $time);
      end_of_test();
    end
  endtask

  task automatic pulse(input bit pll);
    @(posedge clk);
    if (pll) pll_lock_evt <= 1'b1;
    else audio_port_clk_err <= 1'b1;
    @(posedge clk);
    pll_lock_evt       <= 1'b0;
    audio_port_clk_err <= 1'b0;
  endtask

  // counts cycles the pin stays at lvl, never past max
  task automatic run_len(input logic lvl, input int max, output int k);
    k = 0;
    while (irq_out === lvl && k < max) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask

  initial begin
    cyc(2);
    @(posedge clk) rst_n <= 1'b1;
    cyc(3);
    check(irq_out, 1'b1);
    foreach (rows[i]) begin
      if (rows[i].wr) host.write_reg(rows[i].addr, rows[i].data);
      get(rows[i].addr);
      check(d, rows[i].exp);
    end
    // host picks the input function before trusting levels
    @(posedge clk) sel <= '{3'h1, 3'h1, 3'h1, 3'h1};
    gpi_pin <= 4'b0101;
    cyc(4);
    get(`ADDR_GENERAL_INPUT_LEVELS);
    check(d, 8'hA0);
    @(posedge clk) sel[1] <= 3'h2;
    gpi_pin <= 4'hF;
    cyc(4);
    get(`ADDR_GENERAL_INPUT_LEVELS);
    check(d, 8'hB0);
    host.write_reg(`ADDR_INTERRUPT_SETUP, 8'h80);
    host.write_reg(`ADDR_INTERRUPT_SOURCE_MASK, 8'h3F);
    pulse(1'b0);
    cyc(3);
    check(irq_out, 1'b1);
    get(`ADDR_LATCHED_EVENT_FLAGS);
    check(d, 8'h80);
    cyc(3);
    check(irq_out, 1'b0);
    fork
      get(`ADDR_LATCHED_EVENT_FLAGS);
      pulse(1'b1);
    join
    check(d, 8'h00);
    get(`ADDR_LATCHED_EVENT_FLAGS);
    check(d, 8'h40);
    host.write_reg(`ADDR_INTERRUPT_SETUP, 8'h00);
    pulse(1'b0);
    cyc(3);
    check(irq_out, 1'b0);
    get(`ADDR_LATCHED_EVENT_FLAGS);
    check(d, 8'h80);
    // masked pending event stays hidden with the filter on
    host.write_reg(`ADDR_INTERRUPT_SOURCE_MASK, 8'hBF);
    host.write_reg(`ADDR_INTERRUPT_SETUP, 8'h04);
    pulse(1'b0);
    cyc(3);
    check(irq_out, 1'b1);
    get(`ADDR_LATCHED_EVENT_FLAGS);
    check(d, 8'h00);
    host.write_reg(`ADDR_INTERRUPT_SETUP, 8'h00);
    get(`ADDR_LATCHED_EVENT_FLAGS);
    check(d, 8'h80);
    host.write_reg(`ADDR_INTERRUPT_SOURCE_MASK, 8'h7F);
    pulse(1'b1);
    cyc(3);
    check(irq_out, 1'b1);
    get(`ADDR_LATCHED_EVENT_FLAGS);
    check(d, 8'h40);
    host.write_reg(`ADDR_INTERRUPT_SETUP, 8'hC0);
    pulse(1'b0);
    run_len(1'b0, 10, n);
    run_len(1'b1, 2 * PERIOD, n);
    check(n, PULSE);
    run_len(1'b0, 2 * PERIOD, n);
    check(n, PERIOD - PULSE);
    check(irq_out, 1'b1);
    get(`ADDR_LATCHED_EVENT_FLAGS);
    check(d, 8'h80);
    cyc(3);
    check(irq_out, 1'b0);
    host.write_reg(`ADDR_INTERRUPT_SETUP, 8'hE0);
    pulse(1'b0);
    run_len(1'b0, 10, n);
    run_len(1'b1, 2 * PERIOD, n);
    check(n, PULSE);
    run_len(1'b0, 3 * PERIOD, n);
    check(n, 3 * PERIOD);
    // clock error still latched: reserved code keeps the pin idle, level mode raises it
    host.write_reg(`ADDR_INTERRUPT_SETUP, 8'hA0);
    cyc(3);
    check(irq_out, 1'b0);
    host.write_reg(`ADDR_INTERRUPT_SETUP, 8'h80);
    cyc(3);
    check(irq_out, 1'b1);
    @(posedge clk) rst_n <= 1'b0;
    cyc(2);
    check(irq_out, 1'b1);
    @(posedge clk) rst_n <= 1'b1;
    cyc(3);
    get(`ADDR_INTERRUPT_SOURCE_MASK);
    check(d, 8'hFF);
    get(`ADDR_LATCHED_EVENT_FLAGS);
    check(d, 8'h00);
    end_of_test();
  end
endmodule
